// >>> core/imt_timer.sv
// Purpose: Two channel compare match interval timer
// Assumes: Configuration arrives on plain ports; inputs synchronous
// Notes: Outputs are registered
//
// How it works
// - Each counter advances on a tick of PCLK/8, /32, /128 or /512, except channel one in event count mode.
// - Each channel keeps its own count clock selection.
// - Two channels each raise a compare match interrupt pulse.
// - Channel one alone pulses an event output on compare match.
// - A linked event starts, advances or restarts channel one.
// - Only events from the selected source module are acted on.
// - Module stop halts the whole timer until released.
`timescale 1ns/10ps
`default_nettype none
module imt_timer
  import imt_pkg::*;
#(
  parameter int SRC_N = 8
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic mstop_i,
  input var imt_chcfg_t ch0_cfg_i,
  input var imt_chcfg_t ch1_cfg_i,
  input var imt_evcfg_t ev_cfg_i,
  // Linked events, one bit per source module
  input wire logic [SRC_N-1:0] ev_src_i,
  // Status
  output logic [IMT_CNT_W-1:0] cnt0_o,
  output logic [IMT_CNT_W-1:0] cnt1_o,
  output logic irq0_o,
  output logic irq1_o,
  output logic ev_out_o,
  output logic ch1_run_o
);

  // Parameter range check
  if (SRC_N < 1 || SRC_N > 8)
  begin : g_bad_src
    $error("SRC_N must be 1 to 8");
  end

  typedef struct packed {
    logic [IMT_PRE_W-1:0] pre;
    logic [IMT_CNT_W-1:0] cnt0;
    logic [IMT_CNT_W-1:0] cnt1;
    logic hit0;
    logic hit1;
    logic ev_run;
    logic irq0;
    logic irq1;
    logic ev_out;
  } imt_state_t;

  imt_state_t s_q, s_d;

  // Tick when the prescaler wraps at the selected tap
  function automatic logic tick_of(input logic [1:0] cks,
                                   input logic [IMT_PRE_W-1:0] pre);
    logic t;
    t = 1'b0;
    unique case (cks)
      IMT_CKS_DIV8: t = &pre[IMT_TAP_DIV8:0];
      IMT_CKS_DIV32: t = &pre[IMT_TAP_DIV32:0];
      IMT_CKS_DIV128: t = &pre[IMT_TAP_DIV128:0];
      IMT_CKS_DIV512: t = &pre[IMT_TAP_DIV512:0];
    endcase
    return t;
  endfunction : tick_of

  logic tick0, tick1, ev_hit;
  logic [7:0] src_pad;

  always_comb
  begin
    src_pad = 8'h00;
    src_pad[SRC_N-1:0] = ev_src_i;
    ev_hit = src_pad[ev_cfg_i.src_sel] && ev_cfg_i.act != IMT_ACT_NONE;
    tick0 = tick_of(ch0_cfg_i.cks, s_q.pre);
    tick1 = tick_of(ch1_cfg_i.cks, s_q.pre);
  end

  always_comb
  begin
    logic run1;
    logic adv1;
    run1 = 1'b0;
    adv1 = 1'b0;
    s_d = s_q;
    s_d.irq0 = 1'b0;
    s_d.irq1 = 1'b0;
    s_d.ev_out = 1'b0;
    if (!mstop_i)
    begin
      s_d.pre = s_q.pre + 1'b1;
      // Channel zero
      if (ch0_cfg_i.run && tick0)
      begin
        s_d.cnt0 = s_q.hit0 ? IMT_CNT_RST : s_q.cnt0 + 1'b1;
        s_d.hit0 = (s_q.hit0 ? IMT_CNT_RST : s_q.cnt0 + 1'b1)
                   == ch0_cfg_i.cmp;
        s_d.irq0 = s_d.hit0;
      end
      if (ev_hit && ev_cfg_i.act == IMT_ACT_START)
        s_d.ev_run = 1'b1;
      run1 = ch1_cfg_i.run || s_q.ev_run;
      if (ev_cfg_i.act == IMT_ACT_COUNT)
        adv1 = ev_hit;
      else
        adv1 = run1 && tick1;
      if (ev_hit && ev_cfg_i.act == IMT_ACT_RESTART)
      begin
        s_d.cnt1 = IMT_CNT_RST;
        s_d.hit1 = 1'b0;
      end
      else if (adv1)
      begin
        s_d.cnt1 = s_q.hit1 ? IMT_CNT_RST : s_q.cnt1 + 1'b1;
        s_d.hit1 = s_d.cnt1 == ch1_cfg_i.cmp;
        s_d.irq1 = s_d.hit1;
        s_d.ev_out = s_d.hit1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cnt0_o = s_q.cnt0;
  assign cnt1_o = s_q.cnt1;
  assign irq0_o = s_q.irq0;
  assign irq1_o = s_q.irq1;
  assign ev_out_o = s_q.ev_out;
  assign ch1_run_o = s_q.ev_run;

  AST_EVOUT_IRQ1: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev_out_o == irq1_o) else $error("event output differs from irq1");

  AST_IRQ0_MATCH: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq0_o |-> cnt0_o == $past(ch0_cfg_i.cmp))
    else $error("irq0 without compare match");

  AST_IRQ1_PULSE: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq1_o |=> !irq1_o) else $error("irq1 not a pulse");

  AST_IRQ0_PULSE: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq0_o |=> !irq0_o) else $error("irq0 not a pulse");

  AST_EVOUT_MATCH: assert property (@(posedge mclk_i) disable iff (rst_i)
    ev_out_o |-> cnt1_o == $past(ch1_cfg_i.cmp))
    else $error("event output without channel one match");

  AST_STOP_HOLD: assert property (@(posedge mclk_i) disable iff (rst_i)
    mstop_i |=> $stable(cnt0_o) && $stable(cnt1_o) && !irq0_o)
    else $error("counting during module stop");

  AST_STOP_QUIET: assert property (@(posedge mclk_i) disable iff (rst_i)
    mstop_i |=> !irq1_o && !ev_out_o)
    else $error("pulse during module stop");

  AST_STOP_PRE: assert property (@(posedge mclk_i) disable iff (rst_i)
    mstop_i |=> $stable(s_q.pre))
    else $error("prescaler ran during module stop");

  AST_CLEAR: assert property (@(posedge mclk_i) disable iff (rst_i)
    irq0_o && !mstop_i && ch0_cfg_i.run ##0 !$changed(ch0_cfg_i.cks)
    |-> ##[1:512] cnt0_o == IMT_CNT_RST)
    else $error("counter not cleared after match");

  AST_DIV8: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(cnt0_o) && !mstop_i && ch0_cfg_i.cks == IMT_CKS_DIV8
    |-> $past(s_q.pre[2:0]) == 3'h7)
    else $error("div8 tick misplaced");

  AST_DIV512: assert property (@(posedge mclk_i) disable iff (rst_i)
    $changed(cnt0_o) && $past(ch0_cfg_i.cks) == IMT_CKS_DIV512
    |-> &$past(s_q.pre))
    else $error("div512 tick misplaced");

  AST_SRC: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mstop_i && ev_cfg_i.act == IMT_ACT_RESTART && ev_hit
    |=> cnt1_o == IMT_CNT_RST) else $error("restart ignored");

  AST_SRC_IGNORE: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mstop_i && ev_cfg_i.act == IMT_ACT_COUNT && !ev_hit
    |=> $stable(cnt1_o))
    else $error("counted without selected event");

  AST_START: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mstop_i && ev_hit && ev_cfg_i.act == IMT_ACT_START |=> ch1_run_o)
    else $error("start event ignored");

  AST_COUNT_STEP: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mstop_i && ev_hit && ev_cfg_i.act == IMT_ACT_COUNT && !s_q.hit1
    |=> cnt1_o == $past(cnt1_o) + 16'h0001)
    else $error("event count step wrong");

  AST_RESTART_IRQ: assert property (@(posedge mclk_i) disable iff (rst_i)
    !mstop_i && ev_hit && ev_cfg_i.act == IMT_ACT_RESTART |=> !irq1_o)
    else $error("restart raised irq1");

endmodule : imt_timer
`default_nettype wire

// >>> core/imt_pkg.sv
// Purpose: Shared constants and types for the interval match timer
// Assumes: One clock domain, no software register bus
// Notes: Counters are 16 bits wide by default
package imt_pkg;

  // Count clock selections
  localparam logic [1:0] IMT_CKS_DIV8 = 2'h0;
  localparam logic [1:0] IMT_CKS_DIV32 = 2'h1;
  localparam logic [1:0] IMT_CKS_DIV128 = 2'h2;
  localparam logic [1:0] IMT_CKS_DIV512 = 2'h3;

  // Prescaler tap positions (divide by 2**(tap+1))
  localparam int IMT_TAP_DIV8 = 2;
  localparam int IMT_TAP_DIV32 = 4;
  localparam int IMT_TAP_DIV128 = 6;
  localparam int IMT_TAP_DIV512 = 8;
  localparam int IMT_PRE_W = 9;

  // Counter width and reset values
  localparam int IMT_CNT_W = 16;
  localparam logic [IMT_CNT_W-1:0] IMT_CNT_RST = 16'h0000;
  localparam logic [IMT_CNT_W-1:0] IMT_CMP_RST = 16'hffff;

  // Linked event actions for channel one
  typedef enum logic [1:0] {
    IMT_ACT_NONE,
    IMT_ACT_START,
    IMT_ACT_COUNT,
    IMT_ACT_RESTART
  } imt_act_t;

  // Per-channel configuration
  typedef struct packed {
    logic run;
    logic [1:0] cks;
    logic [IMT_CNT_W-1:0] cmp;
  } imt_chcfg_t;

  // Event link configuration
  typedef struct packed {
    logic [2:0] src_sel;
    imt_act_t act;
  } imt_evcfg_t;

endpackage : imt_pkg

// >>> verification/imt_evlink_model.sv
// Purpose: Event link side model driving source event lines
// Assumes: Bench requests one pulse at a time
// Notes: Lines idle low between pulses
`timescale 1ns/10ps
`default_nettype none
module imt_evlink_model
  import imt_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Request from bench
  input wire logic fire_i,
  input wire logic [2:0] src_i,
  // Event lines
  output logic [7:0] ev_o
);
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      ev_o <= 8'h00;
    else
      ev_o <= fire_i ? (8'h01 << src_i) : 8'h00;
endmodule : imt_evlink_model
`default_nettype wire

// >>> verification/tb_compare_match_interval_timer.sv
// Purpose: Self-checking bench for the interval match timer
// Assumes: Inputs change on the falling edge
// Notes: Pulse gaps are measured in clock cycles
`timescale 1ns/10ps
`default_nettype none
module tb_compare_match_interval_timer;
  import imt_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, mstop_i = 1'b0, fire = 1'b0;
  logic [2:0] src = 3'h0;
  imt_chcfg_t ch0_cfg_i = '0, ch1_cfg_i = '0;
  imt_evcfg_t ev_cfg_i = '0;
  logic [7:0] ev_src_i;
  logic [IMT_CNT_W-1:0] cnt0_o, cnt1_o;
  logic irq0_o, irq1_o, ev_out_o, ch1_run_o;
  int n_fail = 0, tests_run = 0, n, i;
  initial
  begin
    forever #25 mclk_i = ~mclk_i;
  end
  imt_timer DUT (.mclk_i, .rst_i, .mstop_i, .ch0_cfg_i, .ch1_cfg_i,
    .ev_cfg_i, .ev_src_i, .cnt0_o, .cnt1_o, .irq0_o, .irq1_o, .ev_out_o,
    .ch1_run_o);
  imt_evlink_model PEER (.mclk_i, .rst_i, .fire_i(fire), .src_i(src),
    .ev_o(ev_src_i));
  task automatic summarize;
    $display("checks %0d fails %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [15:0] exp, got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_irq(input bit ch, output int k);
    k = 0;
    do
    begin
      @(negedge mclk_i);
      k++;
    end
    while ((ch ? irq1_o : irq0_o) !== 1'b1 && k < 9000);
    if (k >= 9000)
    begin
      $display("mismatch irq wait exp 1 got 0");
      n_fail++;
      summarize();
    end
  endtask : wait_irq
  task automatic pulse(input logic [2:0] s);
    src = s;
    fire = 1'b1;
    @(negedge mclk_i);
    fire = 1'b0;
    @(negedge mclk_i);
  endtask : pulse
  initial
  begin
    repeat (4) @(negedge mclk_i);
    rst_i = 1'b0;
    ch0_cfg_i = '{1'b1, IMT_CKS_DIV8, 16'h0001};
    ch1_cfg_i = '{1'b1, IMT_CKS_DIV32, 16'h0003};
    for (i = 0; i < 4; i++)
    begin
      ch0_cfg_i.cks = 2'(i);
      wait_irq(0, n);
      wait_irq(0, n);
      chk("ch0 period", 16'(16 << (2 * i)), 16'(n));
      chk("ch0 at match", 16'h0001, cnt0_o);
      wait_irq(1, n);
      wait_irq(1, n);
      chk("ch1 period", 16'h0080, 16'(n));
      chk("ch1 at match", 16'h0003, cnt1_o);
      chk("event out", 16'h0001, {15'h0000, ev_out_o});
    end
    ch0_cfg_i.cks = IMT_CKS_DIV8;
    ch1_cfg_i = '{1'b0, IMT_CKS_DIV8, 16'h00ff};
    ev_cfg_i = '{3'h3, IMT_ACT_START};
    pulse(3'h2);
    chk("run unselected", 16'h0000, {15'h0000, ch1_run_o});
    pulse(3'h3);
    chk("run selected", 16'h0001, {15'h0000, ch1_run_o});
    repeat (100) @(negedge mclk_i);
    ev_cfg_i.act = IMT_ACT_RESTART;
    pulse(3'h3);
    chk("restart", 16'h0000, cnt1_o);
    ev_cfg_i.act = IMT_ACT_COUNT;
    repeat (3) pulse(3'h3);
    chk("event count", 16'h0003, cnt1_o);
    pulse(3'h2);
    chk("count unselected", 16'h0003, cnt1_o);
    mstop_i = 1'b1;
    repeat (2) pulse(3'h3);
    chk("stopped", 16'h0003, cnt1_o);
    mstop_i = 1'b0;
    pulse(3'h3);
    chk("resumed", 16'h0004, cnt1_o);
    summarize();
  end
endmodule : tb_compare_match_interval_timer
`default_nettype wire
